/* ecr_exception_cause.sv */
module ecr_exception_cause
  import ecr_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire ecr_cop_req_t cop_req_in,
  input  wire ecr_exc_req_t exc_req_in,
  input  wire logic         exception_level_flag_in,
  input  wire logic         boot_vector_select_in,
  input  wire logic         external_irq_ctrl_mode_in,
  input  wire logic         timer_irq_in,
  input  wire logic [2:0]   irq_level_in,
  input  wire logic [1:0]   instruction_set_mode_in,
  output logic      [31:0]  cop_rd_data_out,
  output logic              cop_rd_valid_out,
  output logic              count_enable_out,
  output logic      [1:0]   sw_irq_export_out,
  output logic      [1:0]   sw_irq_local_out,
  output logic      [11:0]  vector_offset_out,
  output logic              vectored_table_out,
  output logic      [31:0]  resume_pc_out,
  output logic              isa_mode_wr_out,
  output logic      [1:0]   isa_mode_wr_data_out,
  output logic      [4:0]   cause_code_out
);

  // ******************************************************************
  // Decode of coprocessor moves
  // ******************************************************************
  logic        hit_cause;
  logic        hit_pc;
  logic        wr_cause;
  logic        wr_pc;
  logic        rd_cause;
  logic        rd_pc;
  logic        capture_ok;
  logic        commit;
  logic [31:0] capture_addr;
  logic [31:0] cause_word;
  logic [31:0] pc_word;
  logic [31:0] nxt_rd_data;
  ecr_cause_t  cause_view;

  assign hit_cause = (cop_req_in.reg_num == ECR_REG_CAUSE) && (cop_req_in.sel == ECR_SEL_CAUSE);
  assign hit_pc    = (cop_req_in.reg_num == ECR_REG_PC) && (cop_req_in.sel == ECR_SEL_PC);
  assign wr_cause  = cop_req_in.wr_en && hit_cause;
  assign wr_pc     = cop_req_in.wr_en && hit_pc;
  assign rd_cause  = cop_req_in.rd_en && hit_cause;
  assign rd_pc     = cop_req_in.rd_en && hit_pc;
  assign commit    = exc_req_in.commit;

  // Branch-delay and resume-address capture is suppressed while already in exception level; cause code and coprocessor number still load
  assign capture_ok   = commit && !exception_level_flag_in;
  assign capture_addr = exc_req_in.in_delay_slot ? exc_req_in.branch_pc
                                                 : exc_req_in.fault_pc;

  // ******************************************************************
  // Hardware-owned cause fields
  // ******************************************************************
  logic       branch_delay_ff;
  logic       timer_pending_ff;
  logic [1:0] coproc_num_ff;
  logic [2:0] irq_level_ff;
  logic [4:0] cause_code_ff;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      branch_delay_ff <= 1'b0;
    end else if (capture_ok) begin
      branch_delay_ff <= exc_req_in.in_delay_slot;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      coproc_num_ff <= 2'h0;
      cause_code_ff <= ECR_EXC_INT;
    end else if (commit) begin
      coproc_num_ff <= exc_req_in.coproc_unit_number;
      cause_code_ff <= exc_req_in.cause_code;
    end
  end

  // Live interrupt state, sampled every cycle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      timer_pending_ff <= 1'b0;
      irq_level_ff     <= 3'h0;
    end else begin
      timer_pending_ff <= timer_irq_in;
      irq_level_ff     <= irq_level_in;
    end
  end

  // ******************************************************************
  // Software-writable cause fields
  // ******************************************************************
  logic       count_stop_ff;
  logic       irq_vec_sel_ff;
  logic [1:0] sw_irq_ff;
  ecr_cause_t wr_view;

  assign wr_view = ecr_cause_t'(cop_req_in.wr_data & ECR_CAUSE_WR_MASK);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_stop_ff  <= 1'b0;
      irq_vec_sel_ff <= 1'b0;
      sw_irq_ff      <= 2'h0;
    end else if (wr_cause) begin
      count_stop_ff  <= wr_view.count_stop;
      irq_vec_sel_ff <= wr_view.irq_vector_select;
      sw_irq_ff      <= wr_view.sw_irq_request;
    end
  end

  // ******************************************************************
  // Outputs driven from the cause fields
  // ******************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_enable_out <= 1'b1;
    end else if (wr_cause) begin
      count_enable_out <= !wr_view.count_stop;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sw_irq_export_out <= 2'h0;
      sw_irq_local_out  <= 2'h0;
    end else begin
      sw_irq_export_out <= external_irq_ctrl_mode_in ? sw_irq_ff : 2'h0;
      sw_irq_local_out  <= external_irq_ctrl_mode_in ? 2'h0 : sw_irq_ff;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cause_code_out <= ECR_EXC_INT;
    end else if (commit) begin
      cause_code_out <= exc_req_in.cause_code;
    end
  end

  // ******************************************************************
  // Resume address and vector selection
  // ******************************************************************
  ecr_resume_pc u_resume_pc (
    .clk_in          (clk_in),
    .reset_in        (reset_in),
    .capture_in      (capture_ok),
    .capture_addr_in (capture_addr),
    .write_in        (wr_pc),
    .write_data_in   (cop_req_in.wr_data),
    .resume_pc_out   (resume_pc_out)
  );

  ecr_vector_sel u_vector_sel (
    .clk_in                (clk_in),
    .reset_in              (reset_in),
    .commit_in             (commit),
    .cause_code_in         (exc_req_in.cause_code),
    .irq_vector_select_in  (irq_vec_sel_ff),
    .boot_vector_select_in (boot_vector_select_in),
    .vector_offset_out     (vector_offset_out),
    .vectored_table_out    (vectored_table_out)
  );

  // Mode bits follow a resume-address write
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      isa_mode_wr_out      <= 1'b0;
      isa_mode_wr_data_out <= 2'h0;
    end else begin
      isa_mode_wr_out <= wr_pc;
      if (wr_pc) begin
        isa_mode_wr_data_out <= {1'b0, cop_req_in.wr_data[ECR_ISA_LOW]};
      end
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  always_comb begin
    cause_view                     = ecr_cause_t'(ECR_CAUSE_RESET);
    cause_view.branch_delay_flag   = branch_delay_ff;
    cause_view.timer_irq_pending   = timer_pending_ff;
    cause_view.coproc_unit_number  = coproc_num_ff;
    cause_view.count_stop          = count_stop_ff;
    cause_view.irq_vector_select   = irq_vec_sel_ff;
    cause_view.requested_irq_level = irq_level_ff;
    cause_view.sw_irq_request      = sw_irq_ff;
    cause_view.cause_code          = cause_code_ff;
  end

  assign cause_word = 32'(cause_view) & ECR_CAUSE_USED_MASK;
  assign pc_word    = (resume_pc_out & ECR_PC_HIGH_MASK)
                    | 32'(instruction_set_mode_in[ECR_ISA_LOW]);

  always_comb begin
    nxt_rd_data = 32'h0000_0000;
    if (rd_cause) begin
      nxt_rd_data = cause_word;
    end else if (rd_pc) begin
      nxt_rd_data = pc_word;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cop_rd_data_out  <= 32'h0000_0000;
      cop_rd_valid_out <= 1'b0;
    end else begin
      cop_rd_data_out  <= nxt_rd_data;
      cop_rd_valid_out <= cop_req_in.rd_en;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_bd_capture;
    commit && !exception_level_flag_in |=> branch_delay_ff == $past(exc_req_in.in_delay_slot);
  endproperty
  a_bd_capture: assert property (p_bd_capture)
    else $error("branch delay flag not captured");

  property p_bd_hold;
    commit && exception_level_flag_in |=> $stable(branch_delay_ff);
  endproperty
  a_bd_hold: assert property (p_bd_hold)
    else $error("branch delay flag changed at exception level");

  property p_timer;
    ##1 timer_pending_ff == $past(timer_irq_in);
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer pending does not follow input");

  property p_coproc;
    commit |=> coproc_num_ff == $past(exc_req_in.coproc_unit_number);
  endproperty
  a_coproc: assert property (p_coproc)
    else $error("coprocessor number not loaded");

  property p_count;
    count_enable_out == !count_stop_ff;
  endproperty
  a_count: assert property (p_count)
    else $error("count enable disagrees with count stop");

  property p_rsvd_zero;
    rd_cause |=> (cop_rd_data_out & ~ECR_CAUSE_USED_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("unimplemented cause bits read nonzero");

  property p_level;
    rd_cause ##1 cop_rd_valid_out |->
      cop_rd_data_out[12:10] == $past(irq_level_ff);
  endproperty
  a_level: assert property (p_level)
    else $error("requested level not shown on read");

  property p_sw_write;
    wr_cause |=> sw_irq_ff == $past(cop_req_in.wr_data[9:8]) ##1
      (sw_irq_export_out | sw_irq_local_out) == $past(sw_irq_ff);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software request bits not written or routed");

  property p_export;
    external_irq_ctrl_mode_in |=> sw_irq_export_out == $past(sw_irq_ff);
  endproperty
  a_export: assert property (p_export)
    else $error("software requests not exported in external mode");

  property p_code;
    commit |=> cause_code_ff == $past(exc_req_in.cause_code) && cause_code_out == cause_code_ff;
  endproperty
  a_code: assert property (p_code)
    else $error("cause code not recorded");

  property p_ro_ignore;
    wr_cause && !commit |=> $stable(cause_code_ff) && $stable(coproc_num_ff);
  endproperty
  a_ro_ignore: assert property (p_ro_ignore)
    else $error("read-only cause field changed by write");

  property p_pc_capture;
    capture_ok |=> resume_pc_out == $past(capture_addr);
  endproperty
  a_pc_capture: assert property (p_pc_capture)
    else $error("resume pc not captured");

  property p_pc_no_capture;
    commit && exception_level_flag_in && !wr_pc |=> $stable(resume_pc_out);
  endproperty
  a_pc_no_capture: assert property (p_pc_no_capture)
    else $error("resume pc captured at exception level");

  property p_pc_read;
    rd_pc |=> cop_rd_data_out[0] == $past(instruction_set_mode_in[ECR_ISA_LOW])
      && cop_rd_data_out[31:1] == $past(resume_pc_out[31:1]);
  endproperty
  a_pc_read: assert property (p_pc_read)
    else $error("resume pc read value wrong");

  property p_isa_write;
    wr_pc |=> isa_mode_wr_out && isa_mode_wr_data_out == {1'b0, $past(cop_req_in.wr_data[0])};
  endproperty
  a_isa_write: assert property (p_isa_write)
    else $error("mode bits not written with resume pc");

endmodule : ecr_exception_cause

/* ecr_irq_ctrl_model.sv */
module ecr_irq_ctrl_model
  import ecr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] sw_irq_in,
  input  wire logic [2:0] src_level_in,
  output logic      [2:0] irq_level_out
);
  // ******************************************************************
  // Interrupt controller: ranks software requests against other sources
  // ******************************************************************
  logic [2:0] sw_level;

  assign sw_level = sw_irq_in[1] ? 3'h2 : (sw_irq_in[0] ? 3'h1 : 3'h0);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_level_out <= 3'h0;
    end else begin
      irq_level_out <= (sw_level > src_level_in) ? sw_level : src_level_in;
    end
  end
endmodule : ecr_irq_ctrl_model

/* ecr_pkg.sv */
package ecr_pkg;

  // ******************************************************************
  // Register numbers reached by coprocessor moves
  // ******************************************************************
  localparam logic [4:0] ECR_REG_CAUSE = 5'h0D;
  localparam logic [4:0] ECR_REG_PC    = 5'h0E;
  localparam logic [2:0] ECR_SEL_CAUSE = 3'h0;
  localparam logic [2:0] ECR_SEL_PC    = 3'h0;

  // ******************************************************************
  // Masks and reset values
  // ******************************************************************
  localparam logic [31:0] ECR_CAUSE_WR_MASK   = 32'h0880_0300;
  localparam logic [31:0] ECR_CAUSE_USED_MASK = 32'hF880_1F7C;
  localparam logic [31:0] ECR_CAUSE_RESET     = 32'h0000_0000;
  localparam logic [31:0] ECR_PC_RESET        = 32'h0000_0000;
  localparam logic [31:0] ECR_PC_HIGH_MASK    = 32'hFFFF_FFFE;
  localparam int          ECR_ISA_LOW         = 0;

  // ******************************************************************
  // Vector offsets
  // ******************************************************************
  localparam logic [11:0] ECR_VEC_GENERAL = 12'h180;
  localparam logic [11:0] ECR_VEC_SPECIAL = 12'h200;

  typedef enum logic [4:0] {
    ECR_EXC_INT   = 5'h00,
    ECR_EXC_ADEL  = 5'h04,
    ECR_EXC_ADES  = 5'h05,
    ECR_EXC_IBUS  = 5'h06,
    ECR_EXC_DBUS  = 5'h07,
    ECR_EXC_SYS   = 5'h08,
    ECR_EXC_BRK   = 5'h09,
    ECR_EXC_RSVD  = 5'h0A,
    ECR_EXC_CPU   = 5'h0B,
    ECR_EXC_OVF   = 5'h0C,
    ECR_EXC_TRAP  = 5'h0D
  } ecr_exc_code_t;

  // Cause register layout, most significant field first
  typedef struct packed {
    logic       branch_delay_flag;
    logic       timer_irq_pending;
    logic [1:0] coproc_unit_number;
    logic       count_stop;
    logic [2:0] rsv_26_24;
    logic       irq_vector_select;
    logic [9:0] rsv_22_13;
    logic [2:0] requested_irq_level;
    logic [1:0] sw_irq_request;
    logic       rsv_7;
    logic [4:0] cause_code;
    logic [1:0] rsv_1_0;
  } ecr_cause_t;

  typedef struct packed {
    logic        commit;
    logic [4:0]  cause_code;
    logic        in_delay_slot;
    logic [1:0]  coproc_unit_number;
    logic [31:0] fault_pc;
    logic [31:0] branch_pc;
  } ecr_exc_req_t;

  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [4:0]  reg_num;
    logic [2:0]  sel;
    logic [31:0] wr_data;
  } ecr_cop_req_t;

endpackage : ecr_pkg

/* ecr_resume_pc.sv */
module ecr_resume_pc
  import ecr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        capture_in,
  input  wire logic [31:0] capture_addr_in,
  input  wire logic        write_in,
  input  wire logic [31:0] write_data_in,
  output logic      [31:0] resume_pc_out
);

  // ******************************************************************
  // Resume address; hardware capture beats a same-cycle write
  // ******************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      resume_pc_out <= ECR_PC_RESET;
    end else if (capture_in) begin
      resume_pc_out <= capture_addr_in;
    end else if (write_in) begin
      resume_pc_out <= write_data_in & ECR_PC_HIGH_MASK;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_pc_write;
    write_in && !capture_in |=> resume_pc_out == ($past(write_data_in) & ECR_PC_HIGH_MASK);
  endproperty
  a_pc_write: assert property (p_pc_write)
    else $error("resume pc write not stored with bit zero clear");

  property p_pc_hold;
    !capture_in && !write_in |=> $stable(resume_pc_out);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("resume pc changed without cause");

endmodule : ecr_resume_pc

/* ecr_vector_sel.sv */
module ecr_vector_sel
  import ecr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        commit_in,
  input  wire logic [4:0]  cause_code_in,
  input  wire logic        irq_vector_select_in,
  input  wire logic        boot_vector_select_in,
  output logic      [11:0] vector_offset_out,
  output logic             vectored_table_out
);

  logic is_irq;

  assign is_irq = (cause_code_in == ECR_EXC_INT);

  // ******************************************************************
  // Dispatch offset latched when the exception commits
  // ******************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      vector_offset_out  <= ECR_VEC_GENERAL;
      vectored_table_out <= 1'b0;
    end else if (commit_in) begin
      vector_offset_out  <= (is_irq && irq_vector_select_in) ? ECR_VEC_SPECIAL
                                                              : ECR_VEC_GENERAL;
      vectored_table_out <= is_irq && irq_vector_select_in && !boot_vector_select_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_special_vec;
    commit_in && is_irq && irq_vector_select_in |=> vector_offset_out == ECR_VEC_SPECIAL;
  endproperty
  a_special_vec: assert property (p_special_vec)
    else $error("interrupt with vector select did not use special vector");

  property p_table;
    commit_in |=> vectored_table_out ==
      ($past(is_irq) && $past(irq_vector_select_in) && !$past(boot_vector_select_in));
  endproperty
  a_table: assert property (p_table)
    else $error("vectored table flag wrong");

endmodule : ecr_vector_sel

/* exception_cause_and_return_pc_bench.sv */
module exception_cause_and_return_pc_bench
  import ecr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk_in, reset_in, lvl_flag, boot_sel, ext_mode, timer_irq;
  ecr_cop_req_t cop_req;
  ecr_exc_req_t exc_req;
  logic [2:0]   irq_level, src_level;
  logic [1:0]   isa_mode, sw_exp, sw_loc, isa_wr_data;
  logic [31:0]  rd_data, resume_pc, e_wr, e_pc, seed, d;
  logic         rd_valid, count_en, vec_tbl, isa_wr, e_bd;
  logic [11:0]  vec_off;
  logic [4:0]   code_out, e_code;
  logic [1:0]   e_ce;
  int           bad_count, samples_checked, cycles;
  ecr_exc_code_t k;

  ecr_exception_cause ecr_exception_cause_inst (
    .clk_in(clk_in), .reset_in(reset_in), .cop_req_in(cop_req), .exc_req_in(exc_req),
    .exception_level_flag_in(lvl_flag), .boot_vector_select_in(boot_sel),
    .external_irq_ctrl_mode_in(ext_mode), .timer_irq_in(timer_irq),
    .irq_level_in(irq_level), .instruction_set_mode_in(isa_mode),
    .cop_rd_data_out(rd_data), .cop_rd_valid_out(rd_valid), .count_enable_out(count_en),
    .sw_irq_export_out(sw_exp), .sw_irq_local_out(sw_loc), .vector_offset_out(vec_off),
    .vectored_table_out(vec_tbl), .resume_pc_out(resume_pc), .isa_mode_wr_out(isa_wr),
    .isa_mode_wr_data_out(isa_wr_data), .cause_code_out(code_out));

  ecr_irq_ctrl_model ecr_irq_ctrl_model_inst (
    .clk_in(clk_in), .reset_in(reset_in), .sw_irq_in(sw_exp),
    .src_level_in(src_level), .irq_level_out(irq_level));

  // ******************************************************************
  // Clock, timeout and checking helpers
  // ******************************************************************
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("[ERR] %0t run hung", $time);
      stop_test();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_flag

  // Level the controller should send back, software requests only in external mode
  function automatic logic [2:0] exp_lvl();
    logic [1:0] sw;
    logic [2:0] sl;
    sw = ext_mode ? e_wr[9:8] : 2'b00;
    sl = sw[1] ? 3'h2 : (sw[0] ? 3'h1 : 3'h0);
    return (sl > src_level) ? sl : src_level;
  endfunction : exp_lvl

  function automatic logic [31:0] exp_cause();
    ecr_cause_t c;
    c = ecr_cause_t'(e_wr & ECR_CAUSE_WR_MASK);
    c.branch_delay_flag   = e_bd;
    c.timer_irq_pending   = timer_irq;
    c.coproc_unit_number  = e_ce;
    c.requested_irq_level = exp_lvl();
    c.cause_code          = e_code;
    return c;
  endfunction : exp_cause

  // One coprocessor move after an idle edge, held for exactly one taking edge
  task automatic cop_move(input logic wr, input logic [4:0] rn, input logic [31:0] dat);
    @(posedge clk_in);
    #2;
    cop_req = '{rd_en: !wr, wr_en: wr, reg_num: rn, sel: 3'h0, wr_data: dat};
    @(posedge clk_in);
    #2;
    cop_req.rd_en = 1'b0;
    cop_req.wr_en = 1'b0;
    if (wr && rn == ECR_REG_CAUSE) e_wr = dat;
  endtask : cop_move

  task automatic read_chk(input logic [4:0] rn, input logic [31:0] exp, input string what);
    cop_move(1'b0, rn, 32'h0000_0000);
    check_flag(rd_valid, 1'b1, "read valid");
    check_word(rd_data, exp, what);
  endtask : read_chk

  // Idle edge first so back-to-back commits never drop and raise in one step
  task automatic commit(input logic [4:0] code, input logic ds, input logic lvl);
    @(posedge clk_in);
    #2;
    exc_req = '{commit: 1'b1, cause_code: code, in_delay_slot: ds,
                coproc_unit_number: $random(seed),
                fault_pc: $random(seed) & ECR_PC_HIGH_MASK,
                branch_pc: $random(seed) & ECR_PC_HIGH_MASK};
    lvl_flag = lvl;
    e_code = code;
    e_ce = exc_req.coproc_unit_number;
    if (!lvl) begin
      e_bd = ds;
      e_pc = ds ? exc_req.branch_pc : exc_req.fault_pc;
    end
    @(posedge clk_in);
    #2;
    exc_req.commit = 1'b0;
  endtask : commit

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    seed = 32'heb82;
    {lvl_flag, boot_sel, ext_mode, timer_irq, src_level, isa_mode} = '0;
    cop_req = '0;
    exc_req = '0;
    {e_wr, e_pc, e_bd, e_code, e_ce} = '0;
    reset_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2;
    reset_in = 1'b0;
    check_flag(count_en, 1'b1, "count enable at reset");
    check_word(vec_off, ECR_VEC_GENERAL, "vector at reset");
    read_chk(ECR_REG_CAUSE, exp_cause(), "cause at reset");
    cop_move(1'b1, ECR_REG_CAUSE, 32'hFFFF_FFFF);
    read_chk(ECR_REG_CAUSE, exp_cause(), "cause all ones");
    repeat (2) @(posedge clk_in);
    check_word(sw_loc, 2'b11, "local requests");
    check_flag(count_en, 1'b0, "count stopped");
    ext_mode = 1'b1;
    repeat (6) @(posedge clk_in);
    check_word(sw_exp, 2'b11, "exported requests");
    check_word(sw_loc, 2'b00, "local off");
    read_chk(ECR_REG_CAUSE, exp_cause(), "level from requests");
    cop_move(1'b1, ECR_REG_CAUSE, 32'h0000_0000);
    src_level = $random(seed);
    timer_irq = 1'b1;
    repeat (6) @(posedge clk_in);
    check_flag(count_en, 1'b1, "count running");
    read_chk(ECR_REG_CAUSE, exp_cause(), "timer and level");
    timer_irq = 1'b0;
    src_level = 3'h0;
    k = k.first();
    do begin
      cop_move(1'b1, ECR_REG_CAUSE, $random(seed));
      boot_sel = $random(seed);
      repeat (4) @(posedge clk_in);
      #2;
      commit(k, $random(seed), $random(seed));
      check_word(code_out, k, "code out");
      check_word(resume_pc, e_pc, "captured pc");
      check_word(vec_off, (k == ECR_EXC_INT && e_wr[23]) ? ECR_VEC_SPECIAL : ECR_VEC_GENERAL,
                 "vector");
      check_flag(vec_tbl, k == ECR_EXC_INT && e_wr[23] && !boot_sel, "table");
      read_chk(ECR_REG_CAUSE, exp_cause(), "cause after commit");
      k = k.next();
    end while (k != k.first());
    cop_move(1'b1, ECR_REG_CAUSE, 32'h0080_0000);
    boot_sel = 1'b0;
    commit(ECR_EXC_INT, 1'b0, 1'b0);
    check_word(vec_off, ECR_VEC_SPECIAL, "special vector");
    check_flag(vec_tbl, 1'b1, "table at normal boot");
    commit(ECR_EXC_SYS, 1'b1, 1'b0);
    commit(ECR_EXC_TRAP, 1'b0, 1'b1);
    check_word(resume_pc, e_pc, "pc kept at level");
    read_chk(ECR_REG_CAUSE, exp_cause(), "flag kept at level");
    repeat (4) begin
      d = $random(seed);
      lvl_flag = 1'b1;
      cop_move(1'b1, ECR_REG_PC, d);
      e_pc = d & ECR_PC_HIGH_MASK;
      check_word(resume_pc, e_pc, "pc write");
      check_flag(isa_wr, 1'b1, "mode write pulse");
      check_word(isa_wr_data, {1'b0, d[0]}, "mode write data");
      isa_mode = $random(seed);
      @(posedge clk_in);
      #2;
      check_flag(isa_wr, 1'b0, "mode pulse ends");
      read_chk(ECR_REG_PC, {e_pc[31:1], isa_mode[ECR_ISA_LOW]}, "pc read");
    end
    read_chk(5'h05, 32'h0000_0000, "unmapped read");
    stop_test();
  end
endmodule : exception_cause_and_return_pc_bench
